/* File: include/ntcp_pkg.sv */
// Purpose: shared constants and types for the network time capture port
// Assumes: 50 MHz core clock, 115200 baud host serial port
// Notes: time packet = flag, source byte, six time bytes (msb first), flag
package ntcp_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BAUD_RATE = 115200;
  localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD_RATE);
  // request processing delay before a requested timestamp is taken
  localparam int unsigned PROC_TIME_US = 2000;
  localparam int unsigned PROC_CYCLES_DEF = PROC_TIME_US * CLK_MHZ;
  // transmit interpacket gap, least time, rounded up
  localparam int unsigned GAP_TIME_NS = 1000;
  localparam logic [15:0] GAP_CYCLES = 16'((GAP_TIME_NS * CLK_MHZ + 999) / 1000);
  // link stays awake this long after the last handshake activity
  localparam int unsigned AWAKE_TIME_US = 10;
  localparam logic [15:0] AWAKE_CYCLES = 16'(AWAKE_TIME_US * CLK_MHZ);
  localparam int unsigned TIME_W = 48;
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [7:0] HDLC_FLAG = 8'h7e;
  localparam logic [7:0] HDLC_ESC = 8'h7d;
  localparam logic [7:0] HDLC_XOR = 8'h20;
  localparam logic [7:0] SRC_STROBE = 8'h01;
  localparam logic [7:0] SRC_REQUEST = 8'h02;
  localparam logic [3:0] IDX_OPEN = 4'h0;
  localparam logic [3:0] IDX_SRC = 4'h1;
  localparam logic [3:0] IDX_TIME0 = 4'h2;
  localparam logic [3:0] IDX_CLOSE = 4'h8;
  localparam logic [3:0] BIT_START = 4'h0;
  localparam logic [3:0] BIT_STOP = 4'h9;
  localparam int unsigned PIN_STROBE = 0;
  localparam int unsigned PIN_CTS = 1;
  localparam int unsigned PIN_RXREQ = 2;
  localparam logic [2:0] PINS_IDLE = 3'h7;
  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_DELAY = 2'b01,
    B_PUSH = 2'b11,
    B_HOLD = 2'b10
  } ntcp_build_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_REQ = 2'b01,
    T_SEND = 2'b11,
    T_GAP = 2'b10
  } ntcp_tx_t;
endpackage

/* File: core/ntcp_fifo.sv */
// Purpose: byte fifo between packet builder and serial transmitter
// Assumes: synchronous active-high reset, shared clock enable
// Notes: out_data is valid whenever out_valid is high
`timescale 1ns/10ps
module ntcp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = clk_en && in_valid && in_ready;
  assign pop = clk_en && out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* File: core/ntcp_capture_port.sv */
// Purpose: network time capture and time packet report over the host serial port
// Assumes: network_time and read_time_req come from logic on clk; handshake pins are asynchronous
// Notes: one packet in flight at a time; strobes while busy are ignored
`timescale 1ns/10ps
module ntcp_capture_port import ntcp_pkg::*; #(
  parameter int unsigned PROC_CYCLES = PROC_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [TIME_W-1:0] network_time,
  input wire logic read_time_req,
  input wire logic time_capture_strobe_n,
  input wire logic host_tx_clear_n,
  input wire logic host_rx_request_n,
  output logic host_tx_request_n,
  output logic host_rx_clear_n,
  output logic host_tx_data,
  output logic link_awake,
  output logic busy
);
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_lvl;
  logic strobe_rise;
  logic cts_low;
  logic rx_req_low;
  ntcp_build_t bstate;
  ntcp_tx_t tstate;
  logic [TIME_W-1:0] latched_time;
  logic [TIME_W-1:0] time_sh;
  logic [7:0] pkt_src;
  logic [31:0] proc_cnt;
  logic req_pending;
  logic req_taken;
  logic [3:0] build_idx;
  logic esc_pend;
  logic pkt_done;
  logic [7:0] raw_byte;
  logic needs_esc;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FIFO_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;
  logic shifting;
  logic [9:0] shreg;
  logic [3:0] bit_idx;
  logic [15:0] bit_cnt;
  logic [15:0] gap_cnt;
  logic [15:0] wake_cnt;
  logic tx_done;

  // three-stage pin synchronisers, level accepted when stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1 <= PINS_IDLE;
      pin_s2 <= PINS_IDLE;
      pin_s3 <= PINS_IDLE;
      pin_lvl <= PINS_IDLE;
    end else if (clk_en) begin
      pin_s1 <= {host_rx_request_n, host_tx_clear_n, time_capture_strobe_n};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));
    end
  end

  assign strobe_rise = pin_s2[PIN_STROBE] && pin_s3[PIN_STROBE] && !pin_lvl[PIN_STROBE];
  assign cts_low = !pin_lvl[PIN_CTS];
  assign rx_req_low = !pin_lvl[PIN_RXREQ];

  // read-time request waits here; a new request beats the clear
  assign req_taken = clk_en && bstate == B_DELAY && !strobe_rise && proc_cnt == 32'(PROC_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (reset) begin
      req_pending <= 1'b0;
    end else if (clk_en) begin
      req_pending <= read_time_req || (req_pending && !req_taken);
    end
  end

  // packet byte source
  assign time_sh = latched_time << {build_idx - IDX_TIME0, 3'b000};
  always_comb begin
    if (build_idx == IDX_OPEN || build_idx == IDX_CLOSE) begin
      raw_byte = HDLC_FLAG;
    end else if (build_idx == IDX_SRC) begin
      raw_byte = pkt_src;
    end else begin
      raw_byte = time_sh[TIME_W-1 -: 8];
    end
  end
  assign needs_esc = build_idx != IDX_OPEN && build_idx != IDX_CLOSE &&
                     (raw_byte == HDLC_FLAG || raw_byte == HDLC_ESC);
  assign fifo_in_data = esc_pend ? (raw_byte ^ HDLC_XOR) : (needs_esc ? HDLC_ESC : raw_byte);
  assign fifo_in_valid = bstate == B_PUSH;

  // capture and packet build
  always_ff @(posedge clk) begin
    if (reset) begin
      bstate <= B_IDLE;
      latched_time <= '0;
      pkt_src <= SRC_STROBE;
      proc_cnt <= '0;
      build_idx <= IDX_OPEN;
      esc_pend <= 1'b0;
      pkt_done <= 1'b0;
      busy <= 1'b0;
    end else if (clk_en) begin
      if (tstate == T_REQ && cts_low) begin
        pkt_done <= 1'b0;
      end
      if (tx_done) begin
        busy <= 1'b0;
      end
      case (bstate)
        B_IDLE, B_DELAY: begin
          proc_cnt <= (bstate == B_IDLE) ? '0 : proc_cnt + 32'h1;
          if (strobe_rise || req_taken) begin
            latched_time <= network_time;
            pkt_src <= strobe_rise ? SRC_STROBE : SRC_REQUEST;
            busy <= 1'b1;
            build_idx <= IDX_OPEN;
            bstate <= B_PUSH;
          end else if (req_pending) begin
            bstate <= B_DELAY;
          end
        end
        B_PUSH: begin
          if (fifo_in_ready) begin
            if (needs_esc && !esc_pend) begin
              esc_pend <= 1'b1;
            end else begin
              esc_pend <= 1'b0;
              build_idx <= build_idx + 4'h1;
              if (build_idx == IDX_CLOSE) begin
                pkt_done <= 1'b1;
                bstate <= B_HOLD;
              end
            end
          end
        end
        B_HOLD: begin
          if (!busy) begin
            bstate <= B_IDLE;
          end
        end
        default: bstate <= B_IDLE;
      endcase
    end
  end

  ntcp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign fifo_out_ready = tstate == T_SEND && !shifting;

  // transmit handshake and serialiser
  always_ff @(posedge clk) begin
    if (reset) begin
      tstate <= T_IDLE;
      host_tx_request_n <= 1'b1;
      host_tx_data <= 1'b1;
      shifting <= 1'b0;
      shreg <= '1;
      bit_idx <= BIT_START;
      bit_cnt <= '0;
      gap_cnt <= '0;
      tx_done <= 1'b0;
    end else if (clk_en) begin
      tx_done <= 1'b0;
      case (tstate)
        T_IDLE: begin
          if (pkt_done && link_awake) begin
            host_tx_request_n <= 1'b0;
            tstate <= T_REQ;
          end
        end
        T_REQ: begin
          if (cts_low) begin
            tstate <= T_SEND;
          end
        end
        T_SEND: begin
          if (!shifting) begin
            if (fifo_out_valid) begin
              shreg <= {1'b1, fifo_out_data, 1'b0};
              host_tx_data <= 1'b0;
              bit_idx <= BIT_START;
              bit_cnt <= '0;
              shifting <= 1'b1;
            end else begin
              host_tx_request_n <= 1'b1;
              tx_done <= 1'b1;
              gap_cnt <= '0;
              tstate <= T_GAP;
            end
          end else if (bit_cnt == BIT_CYCLES - 16'h1) begin
            bit_cnt <= '0;
            if (bit_idx == BIT_STOP) begin
              shifting <= 1'b0;
            end else begin
              shreg <= {1'b1, shreg[9:1]};
              host_tx_data <= shreg[1];
              bit_idx <= bit_idx + 4'h1;
            end
          end else begin
            bit_cnt <= bit_cnt + 16'h1;
          end
        end
        T_GAP: begin
          gap_cnt <= gap_cnt + 16'h1;
          if (gap_cnt == GAP_CYCLES - 16'h1) begin
            tstate <= T_IDLE;
          end
        end
        default: tstate <= T_IDLE;
      endcase
    end
  end

  // link wake and receive clear answer
  always_ff @(posedge clk) begin
    if (reset) begin
      link_awake <= 1'b0;
      wake_cnt <= '0;
      host_rx_clear_n <= 1'b1;
    end else if (clk_en) begin
      if (rx_req_low || pkt_done || tstate != T_IDLE) begin
        link_awake <= 1'b1;
        wake_cnt <= AWAKE_CYCLES;
      end else if (wake_cnt != '0) begin
        wake_cnt <= wake_cnt - 16'h1;
      end else begin
        link_awake <= 1'b0;
      end
      host_rx_clear_n <= !(rx_req_low && link_awake);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_capture_on_rise: assert property (
    clk_en && strobe_rise && (bstate == B_IDLE || bstate == B_DELAY)
      |=> busy && latched_time == $past(network_time) && pkt_src == SRC_STROBE)
    else $error("strobe edge did not latch network time");
  a_packet_opens: assert property (
    $rose(busy) |-> bstate == B_PUSH && build_idx == IDX_OPEN && fifo_in_data == HDLC_FLAG)
    else $error("capture did not start a packet");
  a_request_starts: assert property (
    clk_en && req_pending && bstate == B_IDLE && !strobe_rise |=> bstate == B_DELAY)
    else $error("read request not serviced");
  a_request_delay: assert property (
    $rose(busy) && pkt_src == SRC_REQUEST |-> $past(bstate) == B_DELAY && $past(req_taken))
    else $error("request time taken before processing delay");
  a_rts_has_packet: assert property (
    $fell(host_tx_request_n) |-> tstate == T_REQ && pkt_done)
    else $error("transmit request without a packet");
  a_rx_clear_answer: assert property (
    !host_rx_clear_n |-> $past(rx_req_low) && $past(link_awake))
    else $error("receive clear without host request");
  a_wake_on_req: assert property (
    clk_en && rx_req_low |=> link_awake)
    else $error("receive request did not wake link");
  a_no_pause: assert property (
    clk_en && tstate == T_SEND && !shifting && fifo_out_valid |=> shifting && !host_tx_request_n)
    else $error("transmit paused inside a packet");
  a_gap_held: assert property (
    $rose(host_tx_request_n) |-> host_tx_request_n [*8])
    else $error("interpacket gap too short");
  a_frame_bits: assert property (
    shifting && (bit_idx == BIT_STOP || bit_idx == BIT_START) |-> host_tx_data == (bit_idx == BIT_STOP))
    else $error("bad start or stop bit");
  a_time_stable: assert property (
    busy && $past(busy) |-> $stable(latched_time))
    else $error("latched time changed while in flight");
endmodule

/* File: testbench/ntcp_host_model.sv */
// Purpose: companion host model on the host serial port
// Assumes: pins change on the falling clock edge, serial line sampled mid-bit
// Notes: received bytes land raw in rx_q, bad stop bits in frame_errs
`timescale 1ns/10ps
module ntcp_host_model import ntcp_pkg::*; (
  input wire logic clk,
  input wire logic ready,
  input wire logic host_tx_request_n,
  input wire logic host_tx_data,
  output logic time_capture_strobe_n,
  output logic host_tx_clear_n,
  output logic host_rx_request_n
);
  logic [7:0] rx_q[$];
  int frame_errs = 0;

  initial begin
    time_capture_strobe_n = 1'b1;
    host_rx_request_n = 1'b1;
  end

  // clear answers a pending request while the host is ready
  assign host_tx_clear_n = ~(ready & ~host_tx_request_n);

  task automatic strobe();
    @(negedge clk);
    time_capture_strobe_n = 1'b0;
    repeat (4) @(negedge clk);
    time_capture_strobe_n = 1'b1;
  endtask

  task automatic rx_req(input logic lvl);
    @(negedge clk);
    host_rx_request_n = lvl;
  endtask

  // 8 data bits lsb first, one stop bit, no parity
  initial forever begin : uart_rx
    logic [7:0] b;
    @(negedge clk);
    if (host_tx_data === 1'b0) begin
      repeat (BIT_CYCLES / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(negedge clk);
        b[i] = host_tx_data;
      end
      repeat (BIT_CYCLES) @(negedge clk);
      if (host_tx_data !== 1'b1) frame_errs++;
      rx_q.push_back(b);
    end
  end
endmodule

/* File: testbench/ntcp_capture_port_tb_top.sv */
// Purpose: self-checking bench for the network time capture port
// Assumes: 50 MHz clock, inputs change on the falling edge
// Notes: low time bits come from a 6-bit counter, so only the top byte needs escaping
`timescale 1ns/10ps
module ntcp_capture_port_tb_top import ntcp_pkg::*;;
  localparam int PROC = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic read_time_req = 1'b0;
  logic ready = 1'b0;
  logic clk_en = 1'b1;
  logic [5:0] cnt = 6'h0;
  logic [47:0] network_time;
  logic time_capture_strobe_n, host_tx_clear_n, host_rx_request_n;
  logic host_tx_request_n, host_rx_clear_n, host_tx_data, link_awake, busy;
  int num_errors = 0;
  int checks_done = 0;
  int gap_cnt = 0;

  assign network_time = {40'h7e11a51234, 2'h0, cnt};
  initial forever #10 clk = ~clk;
  always @(negedge clk) cnt <= cnt + 6'h1;

  ntcp_capture_port #(.PROC_CYCLES(PROC)) DUT (.clk(clk), .reset(reset), .clk_en(clk_en),
    .network_time(network_time), .read_time_req(read_time_req),
    .time_capture_strobe_n(time_capture_strobe_n), .host_tx_clear_n(host_tx_clear_n),
    .host_rx_request_n(host_rx_request_n), .host_tx_request_n(host_tx_request_n),
    .host_rx_clear_n(host_rx_clear_n), .host_tx_data(host_tx_data), .link_awake(link_awake), .busy(busy));

  ntcp_host_model host (.clk(clk), .ready(ready), .host_tx_request_n(host_tx_request_n),
    .host_tx_data(host_tx_data), .time_capture_strobe_n(time_capture_strobe_n),
    .host_tx_clear_n(host_tx_clear_n), .host_rx_request_n(host_rx_request_n));

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return busy;
      1: return host_tx_request_n;
      3: return host.rx_q.size() != 0;
      default: return host_rx_clear_n;
    endcase
  endfunction

  task automatic wait_for(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (pick(k) !== v) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        check(48'(pick(k)), 48'(v));
        final_report();
      end
    end
  endtask

  // measures the idle time of transmit request before each assertion
  always @(negedge clk) begin
    if (reset || host_tx_request_n === 1'b1) begin
      gap_cnt <= gap_cnt + 1;
    end else if (gap_cnt != 0) begin
      check(48'(gap_cnt >= int'(GAP_CYCLES)), 48'h1);
      gap_cnt <= 0;
    end
  end

  task automatic check_packet(input logic [7:0] src, input logic [5:0] base, output logic [5:0] d);
    logic [7:0] b[$];
    logic [7:0] x;
    check(48'(host.rx_q.size()), 48'd10);
    while (host.rx_q.size() > 0) begin
      x = host.rx_q.pop_front();
      if (x === HDLC_ESC && host.rx_q.size() > 0) x = host.rx_q.pop_front() ^ HDLC_XOR;
      b.push_back(x);
    end
    d = 6'h3f;
    check(48'(b.size()), 48'd9);
    if (b.size() == 9) begin
      check(48'({b[0], b[1], b[8]}), 48'({HDLC_FLAG, src, HDLC_FLAG}));
      check({b[2], b[3], b[4], b[5], b[6], b[7][7:6], 6'h0}, {40'h7e11a51234, 8'h0});
      d = b[7][5:0] - base;
    end
  endtask

  task automatic t_wake();
    int n;
    check(48'({host_tx_request_n, host_rx_clear_n, host_tx_data, link_awake, busy}), 48'h1c);
    host.rx_req(1'b0);
    wait_for(2, 1'b0, 10, n);
    check(48'(n >= 4 && n <= 6), 48'h1);
    check(48'(link_awake), 48'h1);
    host.rx_req(1'b1);
    wait_for(2, 1'b1, 10, n);
    check(48'(host_tx_request_n), 48'h1);
  endtask

  task automatic t_strobe();
    int n;
    logic [5:0] c0;
    logic [5:0] d;
    repeat (600) @(negedge clk);
    check(48'(link_awake), 48'h0);
    host.strobe();
    c0 = cnt;
    wait_for(0, 1'b1, 10, n);
    check(48'(busy), 48'h1);
    wait_for(1, 1'b0, 100, n);
    check(48'(link_awake), 48'h1);
    repeat (100) @(negedge clk);
    check(48'({host_tx_request_n, host_tx_data}), 48'h1);
    ready = 1'b1;
    wait_for(3, 1'b1, 6000, n);
    ready = 1'b0;
    check(48'(host.rx_q.size()), 48'h1);
    host.strobe();
    wait_for(0, 1'b0, 50000, n);
    check(48'(host_tx_request_n), 48'h1);
    check(48'(host.frame_errs), 48'h0);
    check_packet(SRC_STROBE, c0, d);
    check(48'(d <= 6'h6), 48'h1);
  endtask

  task automatic t_request();
    int n;
    logic [5:0] c0;
    logic [5:0] d;
    read_time_req = 1'b1;
    c0 = cnt;
    ready = 1'b1;
    @(negedge clk);
    read_time_req = 1'b0;
    wait_for(0, 1'b1, PROC + 20, n);
    check(48'(n >= PROC), 48'h1);
    wait_for(0, 1'b0, 50000, n);
    check_packet(SRC_REQUEST, c0, d);
    check(48'(d >= 6'(PROC) && d <= 6'(PROC + 6)), 48'h1);
    repeat (200) @(negedge clk);
    check(48'({host_tx_request_n, busy}), 48'h2);
  endtask

  // clock enable low freezes the synchronisers, so the clear answer waits
  task automatic t_freeze();
    int n;
    clk_en = 1'b0;
    host.rx_req(1'b0);
    repeat (20) @(negedge clk);
    check(48'({host_rx_clear_n, link_awake}), 48'h3);
    clk_en = 1'b1;
    wait_for(2, 1'b0, 10, n);
    check(48'(n >= 4 && n <= 6), 48'h1);
    host.rx_req(1'b1);
    wait_for(2, 1'b1, 10, n);
    check(48'(host_rx_clear_n), 48'h1);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    t_wake();
    $display("test wake done");
    t_strobe();
    $display("test strobe done");
    t_request();
    $display("test request done");
    t_freeze();
    $display("test freeze done");
    final_report();
  end
endmodule
